// *** hw/mlsr_top.sv ***
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module mlsr_uart_line (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [15:0] cfg_in,
	input wire logic rx_tick_in,
	input wire logic tx_tick_in,
	input wire logic rx_pin_in,
	output logic tx_pin_out,
	input wire logic tx_load_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_empty_out,
	output logic rx_full_out,
	output logic [10:0] rx_word_out,
	input wire logic rx_take_in
);
	typedef struct packed {
		logic rx_busy;
		logic [3:0] rx_os;
		logic [3:0] rx_idx;
		logic [7:0] rx_sh;
		logic rx_par;
		logic [7:0] rx_hold;
		logic rx_pe;
		logic rx_fe;
		logic rx_oe;
		logic rx_full;
		logic [7:0] tx_hold;
		logic tx_full;
		logic tx_busy;
		logic [7:0] tx_left;
		logic [3:0] tx_os;
		logic [11:0] tx_sh;
	} mlsr_line_type;
	mlsr_line_type q, d;
	logic [3:0] len;
	logic par_en, odd, hdx;
	logic [7:0] txd;
	logic [11:0] frame;
	logic [3:0] nbits;
	logic [7:0] stop_ticks;

	always_comb begin
		d = q;
		len = mlsr_pkg::MIN_CHAR_LEN + {2'h0, cfg_in[mlsr_pkg::CFG_LEN_LSB +: 2]};
		par_en = cfg_in[mlsr_pkg::CFG_PAR_BIT];
		odd = cfg_in[mlsr_pkg::CFG_ODD_BIT] & par_en;
		hdx = cfg_in[mlsr_pkg::CFG_HDX_BIT];
		txd = q.tx_hold & (8'hff >> (4'h8 - len));
		frame = 12'hfff;
		frame[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < len) begin
				frame[i + 1] = txd[i];
			end
		end
		if (par_en) begin
			frame[4'(len + 4'h1)] = (^txd) ^ odd;
		end
		nbits = 4'h1 + len + {3'h0, par_en};
		if (!cfg_in[mlsr_pkg::CFG_STOP2_BIT]) begin
			stop_ticks = mlsr_pkg::STOP_TICKS_1;
		end else if (len == mlsr_pkg::MIN_CHAR_LEN) begin
			stop_ticks = mlsr_pkg::STOP_TICKS_15;
		end else begin
			stop_ticks = mlsr_pkg::STOP_TICKS_2;
		end
		// Transmit engine: hold register feeds the shifter as soon as it is idle
		if (!q.tx_busy) begin
			if (q.tx_full) begin
				d.tx_sh = frame;
				d.tx_busy = 1'b1;
				d.tx_full = 1'b0;
				d.tx_os = 4'h0;
				d.tx_left = {nbits, 4'h0} + stop_ticks;
			end
		end else if (tx_tick_in) begin
			d.tx_left = q.tx_left - 8'h1;
			d.tx_os = q.tx_os + 4'h1;
			if (q.tx_os == 4'hf) begin
				d.tx_sh = {1'b1, q.tx_sh[11:1]};
			end
			if (q.tx_left == 8'h1) begin
				d.tx_busy = 1'b0;
				d.tx_sh = 12'hfff;
			end
		end
		if (tx_load_in) begin
			d.tx_hold = tx_data_in;
			d.tx_full = 1'b1;
		end
		if (rx_take_in) begin
			d.rx_full = 1'b0;
		end
		if (q.rx_busy && hdx && q.tx_busy) begin
			d.rx_busy = 1'b0;
		end else if (rx_tick_in) begin
			if (!q.rx_busy) begin
				if (!rx_pin_in && !(hdx && q.tx_busy)) begin
					d.rx_busy = 1'b1;
					d.rx_os = 4'h0;
					d.rx_idx = 4'h0;
					d.rx_sh = 8'h00;
					d.rx_par = 1'b0;
				end
			end else begin
				d.rx_os = q.rx_os + 4'h1;
				if (q.rx_os == mlsr_pkg::MID_TICK) begin
					d.rx_idx = q.rx_idx + 4'h1;
					if (q.rx_idx == 4'h0) begin
						// A start bit gone by mid-bit was noise
						d.rx_busy = !rx_pin_in;
					end else if (q.rx_idx <= len) begin
						d.rx_sh[3'(q.rx_idx - 4'h1)] = rx_pin_in;
					end else if (par_en && q.rx_idx == len + 4'h1) begin
						d.rx_par = rx_pin_in;
					end else begin
						d.rx_busy = 1'b0;
						d.rx_hold = q.rx_sh;
						d.rx_pe = par_en & (((^q.rx_sh) ^ q.rx_par) != odd);
						d.rx_fe = !rx_pin_in;
						// The unserviced character is overwritten; the survivor carries the mark
						d.rx_oe = q.rx_full & !rx_take_in;
						d.rx_full = 1'b1;
						if (cfg_in[mlsr_pkg::CFG_ECHO_BIT] && !d.tx_full) begin
							d.tx_hold = q.rx_sh;
							d.tx_full = 1'b1;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			q <= '0;
			q.tx_sh <= 12'hfff;
		end else begin
			q <= d;
		end
	end

	assign tx_pin_out = q.tx_sh[0];
	assign tx_empty_out = !q.tx_full;
	assign rx_full_out = q.rx_full;
	assign rx_word_out = {q.rx_oe, q.rx_fe, q.rx_pe, q.rx_hold};
endmodule

// Function
// - Character right-justified in bits 7..0
// - Bits 11..8 carry arrival line number
// - Bit 12 flags parity mismatch
// - Bit 13 flags missing stop bit
// - Bit 14 flags earlier lost character
// - Bit 15 marks word valid
// - Write-only config stored to selected line
// - Bits 1..0 pick five to eight bits
// - Bit 2 two stop, 1.5 at five
// - Bit 4 enables parity generate and check
// - Bit 5 odd else even parity
// - Separate receive and transmit rate codes
// - Rate code table with two external clocks
// - Half duplex blinds receiver while transmitting
// - Echo received characters back out
// - Address write takes extension bits from control
// - Address read gives low sixteen bits
// - Count loaded negative, counts up to zero
// - Active bit starts memory-fed transmission
// - Active clears when last character loaded
// - Control bits 3..0 select the line
// - Count reaching zero sets transmit flag
// - Status bits 7..6 show extension bits
module mlsr_top #(
	parameter int unsigned CLK_HZ = mlsr_pkg::CLK_HZ,
	parameter int unsigned SILO_DEPTH = mlsr_pkg::SILO_DEPTH
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [15:0] rx_line_in,
	output logic [15:0] tx_line_out,
	input wire logic ext_clk_a_in,
	input wire logic ext_clk_b_in,
	output logic bus_master_fetch_req_out,
	output logic [17:0] bus_master_fetch_addr_out,
	input wire logic bus_master_fetch_ack_in,
	input wire logic [7:0] bus_master_fetch_data_in
);
	localparam int SW = $clog2(SILO_DEPTH);
	typedef struct packed {
		logic [3:0] sel;
		logic [1:0] ext;
		logic tx_flag;
		logic [15:0][15:0] cfg;
		logic [15:0][17:0] addr;
		logic [15:0][15:0] cnt;
		logic [15:0] act;
		logic [SILO_DEPTH-1:0][14:0] silo;
		logic [SW-1:0] head;
		logic [SW-1:0] tail;
		logic [SW:0] fill;
		logic [3:0] scan;
		logic [mlsr_pkg::NUM_RATES-1:0][17:0] div;
		logic ext_a;
		logic ext_b;
		mlsr_pkg::mlsr_fetch_type fst;
		logic [3:0] fline;
		logic [17:0] faddr;
		logic aw_got;
		logic [7:0] waddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mlsr_state_type;
	mlsr_state_type q, d;
	logic [15:0] rx_full, tx_empty, take, load, tick_vec;
	logic [10:0] rx_word [16];
	logic flag_set, push, pop, wr_fire, ar_fire;
	logic [17:0] cur_addr, sel_addr;
	logic [15:0] cur_cnt;
	logic [14:0] head_word;

	function automatic logic [17:0] div_of(input int r);
		return 18'((64'(CLK_HZ) * 64'd10) / (64'(mlsr_pkg::OVERSAMPLE) * 64'(mlsr_pkg::BAUD_X10[r])) - 64'd1);
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
		return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	always_comb begin
		tick_vec[0] = 1'b0;
		for (int r = 0; r < mlsr_pkg::NUM_RATES; r++) begin
			tick_vec[r + 1] = q.div[r] == 18'h0;
		end
		tick_vec[14] = ext_clk_a_in & !q.ext_a;
		tick_vec[15] = ext_clk_b_in & !q.ext_b;
	end

	for (genvar i = 0; i < 16; i++) begin : g_line
		mlsr_uart_line u_line (
			.clk_in(clk_in),
			.sys_rst_in(sys_rst_in),
			.cfg_in(q.cfg[i]),
			.rx_tick_in(tick_vec[q.cfg[i][mlsr_pkg::CFG_RXRATE_LSB +: 4]]),
			.tx_tick_in(tick_vec[q.cfg[i][mlsr_pkg::CFG_TXRATE_LSB +: 4]]),
			.rx_pin_in(rx_line_in[i]),
			.tx_pin_out(tx_line_out[i]),
			.tx_load_in(load[i]),
			.tx_data_in(bus_master_fetch_data_in),
			.tx_empty_out(tx_empty[i]),
			.rx_full_out(rx_full[i]),
			.rx_word_out(rx_word[i]),
			.rx_take_in(take[i])
		);
	end

	assign wr_fire = q.aw_got & q.w_got & !q.bvalid;
	assign ar_fire = s_axi_arvalid_in & !q.rvalid;
	assign cur_addr = q.addr[q.fline];
	assign cur_cnt = q.cnt[q.fline];
	assign sel_addr = q.addr[q.sel];
	assign head_word = q.silo[q.head];

	always_comb begin
		d = q;
		take = 16'h0;
		load = 16'h0;
		flag_set = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		for (int r = 0; r < mlsr_pkg::NUM_RATES; r++) begin
			d.div[r] = (q.div[r] == 18'h0) ? div_of(r) : q.div[r] - 18'h1;
		end
		d.ext_a = ext_clk_a_in;
		d.ext_b = ext_clk_b_in;
		// Scanner visits one line per cycle; a full buffer leaves the character in its line
		if (rx_full[q.scan] && q.fill < (SW + 1)'(SILO_DEPTH)) begin
			take[q.scan] = 1'b1;
			push = 1'b1;
			d.silo[q.tail] = {rx_word[q.scan][10:8], q.scan, rx_word[q.scan][7:0]};
			d.tail = q.tail + 1'b1;
		end
		d.scan = q.scan + 4'h1;
		case (q.fst)
			mlsr_pkg::FETCH_IDLE: begin
				if (q.act[q.fline] && tx_empty[q.fline]) begin
					if (cur_cnt == 16'h0) begin
						d.act[q.fline] = 1'b0;
						flag_set = 1'b1;
						d.fline = q.fline + 4'h1;
					end else begin
						d.fst = mlsr_pkg::FETCH_REQ;
						d.faddr = cur_addr;
					end
				end else begin
					d.fline = q.fline + 4'h1;
				end
			end
			mlsr_pkg::FETCH_REQ: begin
				if (bus_master_fetch_ack_in) begin
					load[q.fline] = 1'b1;
					d.addr[q.fline] = cur_addr + 18'h1;
					d.cnt[q.fline] = cur_cnt + 16'h1;
					if (cur_cnt == 16'hffff) begin
						d.act[q.fline] = 1'b0;
						flag_set = 1'b1;
					end
					d.fst = mlsr_pkg::FETCH_IDLE;
					d.fline = q.fline + 4'h1;
				end
			end
			default: begin
				d.fst = mlsr_pkg::FETCH_IDLE;
			end
		endcase
		if (!q.aw_got && s_axi_awvalid_in) begin
			d.aw_got = 1'b1;
			d.waddr = {s_axi_awaddr_in[7:2], 2'h0};
		end
		if (!q.w_got && s_axi_wvalid_in) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata_in;
			d.wstrb = s_axi_wstrb_in;
		end
		if (q.bvalid && s_axi_bready_in) begin
			d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = mlsr_pkg::RESP_OKAY;
			case (q.waddr)
				mlsr_pkg::ADDR_CTRL: begin
					if (q.wstrb[0]) begin
						d.sel = q.wdata[mlsr_pkg::CTRL_SEL_LSB +: 4];
						d.ext = q.wdata[mlsr_pkg::CTRL_EXT_LSB +: 2];
					end
					if (q.wstrb[1]) begin
						d.tx_flag = q.wdata[mlsr_pkg::CTRL_TXFLAG_BIT];
					end
				end
				mlsr_pkg::ADDR_LCFG: d.cfg[q.sel] = merge16(q.cfg[q.sel], q.wdata, q.wstrb);
				mlsr_pkg::ADDR_TXADDR: d.addr[q.sel] = {q.ext, merge16(sel_addr[15:0], q.wdata, q.wstrb)};
				mlsr_pkg::ADDR_TXCNT: d.cnt[q.sel] = merge16(q.cnt[q.sel], q.wdata, q.wstrb);
				mlsr_pkg::ADDR_TXACT: d.act = merge16(q.act, q.wdata, q.wstrb);
				mlsr_pkg::ADDR_RXCHAR, mlsr_pkg::ADDR_SILOST: d.bresp = mlsr_pkg::RESP_OKAY;
				default: d.bresp = mlsr_pkg::RESP_SLVERR;
			endcase
		end
		if (q.rvalid && s_axi_rready_in) begin
			d.rvalid = 1'b0;
		end
		if (ar_fire) begin
			d.rvalid = 1'b1;
			d.rresp = mlsr_pkg::RESP_OKAY;
			d.rdata = 32'h0;
			case ({s_axi_araddr_in[7:2], 2'h0})
				mlsr_pkg::ADDR_CTRL: d.rdata = {16'h0, q.tx_flag, 9'h0, q.ext, q.sel};
				mlsr_pkg::ADDR_RXCHAR: begin
					if (q.fill != '0) begin
						d.rdata = {16'h0, 1'b1, head_word};
						pop = 1'b1;
						d.head = q.head + 1'b1;
					end
				end
				mlsr_pkg::ADDR_LCFG: d.rdata = 32'h0;
				mlsr_pkg::ADDR_TXADDR: d.rdata = {16'h0, sel_addr[15:0]};
				mlsr_pkg::ADDR_TXCNT: d.rdata = {16'h0, q.cnt[q.sel]};
				mlsr_pkg::ADDR_TXACT: d.rdata = {16'h0, q.act};
				mlsr_pkg::ADDR_SILOST: begin
					d.rdata[mlsr_pkg::SST_EXT_LSB +: 2] = sel_addr[17:16];
					d.rdata[mlsr_pkg::SST_FILL_LSB +: 6] = q.fill[5:0];
				end
				default: d.rresp = mlsr_pkg::RESP_SLVERR;
			endcase
		end
		d.fill = q.fill + (SW + 1)'(push) - (SW + 1)'(pop);
		// Hardware set beats a software clear in the same cycle
		if (flag_set) begin
			d.tx_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready_out = !q.aw_got;
	assign s_axi_wready_out = !q.w_got;
	assign s_axi_bvalid_out = q.bvalid;
	assign s_axi_bresp_out = q.bresp;
	assign s_axi_arready_out = !q.rvalid;
	assign s_axi_rvalid_out = q.rvalid;
	assign s_axi_rdata_out = q.rdata;
	assign s_axi_rresp_out = q.rresp;
	assign bus_master_fetch_req_out = q.fst == mlsr_pkg::FETCH_REQ;
	assign bus_master_fetch_addr_out = q.faddr;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	rx_empty_read_a: assert property (ar_fire && s_axi_araddr_in == mlsr_pkg::ADDR_RXCHAR && q.fill == '0
		|=> s_axi_rvalid_out && s_axi_rdata_out == 32'h0) else $error("empty read not invalid");
	rx_word_a: assert property (ar_fire && s_axi_araddr_in == mlsr_pkg::ADDR_RXCHAR && q.fill != '0
		|=> s_axi_rdata_out[15:0] == {1'b1, $past(head_word)}) else $error("wrong received word");
	rx_pop_a: assert property (ar_fire && s_axi_araddr_in == mlsr_pkg::ADDR_RXCHAR && q.fill != '0 && !push
		|=> q.fill == $past(q.fill) - 1'b1) else $error("read did not remove entry");
	last_flag_a: assert property (bus_master_fetch_req_out && bus_master_fetch_ack_in && cur_cnt == 16'hffff
		|=> q.tx_flag) else $error("flag not set at zero count");
	last_clear_a: assert property (bus_master_fetch_req_out && bus_master_fetch_ack_in && cur_cnt == 16'hffff
		&& !wr_fire |=> !q.act[$past(q.fline)]) else $error("active not cleared");
	addr_step_a: assert property (bus_master_fetch_req_out && bus_master_fetch_ack_in && !wr_fire
		|=> q.addr[$past(q.fline)] == $past(cur_addr) + 18'h1) else $error("address not stepped");
	fetch_addr_a: assert property (!bus_master_fetch_req_out ##1 bus_master_fetch_req_out
		|-> bus_master_fetch_addr_out == $past(cur_addr)) else $error("fetch address wrong");
	ext_load_a: assert property (wr_fire && q.waddr == mlsr_pkg::ADDR_TXADDR
		|=> q.addr[$past(q.sel)][17:16] == $past(q.ext)) else $error("extension bits not taken");
	addr_read_a: assert property (ar_fire && s_axi_araddr_in == mlsr_pkg::ADDR_TXADDR
		|=> s_axi_rdata_out == {16'h0, $past(sel_addr[15:0])}) else $error("address read wrong");
	silo_ext_a: assert property (ar_fire && s_axi_araddr_in == mlsr_pkg::ADDR_SILOST
		|=> s_axi_rdata_out[7:6] == $past(sel_addr[17:16])) else $error("status extension wrong");
	cfg_store_a: assert property (wr_fire && q.waddr == mlsr_pkg::ADDR_LCFG && q.wstrb == 4'hf
		|=> q.cfg[$past(q.sel)] == $past(q.wdata[15:0])) else $error("config not stored");
endmodule

// *** common/mlsr_pkg.sv ***
package mlsr_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned NUM_LINES = 16;
	localparam int unsigned SILO_DEPTH = 64;
	localparam int unsigned NUM_RATES = 13;
	// Baud rates in tenths of a baud so that 134.5 stays exact
	localparam int unsigned BAUD_X10 [NUM_RATES] = '{500, 750, 1100, 1345, 1500, 2000, 3000, 6000, 12000, 18000,
		24000, 48000, 96000};
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RXCHAR = 8'h04;
	localparam logic [7:0] ADDR_LCFG = 8'h08;
	localparam logic [7:0] ADDR_TXADDR = 8'h0c;
	localparam logic [7:0] ADDR_TXCNT = 8'h10;
	localparam logic [7:0] ADDR_TXACT = 8'h14;
	localparam logic [7:0] ADDR_SILOST = 8'h1c;
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_EXT_LSB = 4;
	localparam int CTRL_TXFLAG_BIT = 15;
	localparam int RX_VALID_BIT = 15;
	localparam int CFG_LEN_LSB = 0;
	localparam int CFG_STOP2_BIT = 2;
	localparam int CFG_PAR_BIT = 4;
	localparam int CFG_ODD_BIT = 5;
	localparam int CFG_RXRATE_LSB = 6;
	localparam int CFG_TXRATE_LSB = 10;
	localparam int CFG_HDX_BIT = 14;
	localparam int CFG_ECHO_BIT = 15;
	localparam int SST_EXT_LSB = 6;
	localparam int SST_FILL_LSB = 8;
	localparam logic [3:0] MIN_CHAR_LEN = 4'h5;
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [7:0] STOP_TICKS_1 = 8'h10;
	localparam logic [7:0] STOP_TICKS_15 = 8'h18;
	localparam logic [7:0] STOP_TICKS_2 = 8'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		FETCH_IDLE = 2'h0,
		FETCH_REQ = 2'h1
	} mlsr_fetch_type;
endpackage

// *** bench/mlsr_term_model.sv ***
`timescale 1ns/1ps
module mlsr_term_model #(
	parameter int BIT_CYC = 64
) (
	input wire logic clk_in,
	output logic [15:0] rx_line_out,
	input wire logic [15:0] tx_line_in
);
	// Idle mark on every line until a frame is sent
	initial rx_line_out = 16'hffff;

	task automatic hold_bit(input int l, input logic v);
		@(posedge clk_in);
		rx_line_out[l] <= v;
		repeat (BIT_CYC - 1) @(posedge clk_in);
	endtask

	// Start, data bits LSB first, optional parity, one stop slot, then idle marks
	task automatic send_char(input int l, input logic [7:0] d, input int nb, input logic pen, input logic pb,
		input logic stopv);
		hold_bit(l, 1'b0);
		for (int i = 0; i < nb; i++) hold_bit(l, d[i]);
		if (pen) hold_bit(l, pb);
		hold_bit(l, stopv);
		hold_bit(l, 1'b1);
		hold_bit(l, 1'b1);
	endtask

	// Samples mid-bit; a frame already under way when called is missed, so call before it starts
	task automatic get_char(input int l, input int nb, input logic pen, output logic [8:0] d, output logic stopv);
		d = '0;
		do @(posedge clk_in); while (tx_line_in[l] !== 1'b0);
		repeat (BIT_CYC / 2) @(posedge clk_in);
		for (int i = 0; i < nb + int'(pen); i++) begin
			repeat (BIT_CYC) @(posedge clk_in);
			d[i] = tx_line_in[l];
		end
		repeat (BIT_CYC) @(posedge clk_in);
		stopv = tx_line_in[l];
	endtask
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	// Small clock figure so that rate code 1101 ticks every 4 cycles: 64 cycles a bit
	localparam int unsigned CLK_HZ = 16 * 9600 * 4;
	localparam int LIMIT = 30000;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] awaddr = '0;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = '0;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic [15:0] rx_line;
	logic [15:0] tx_line;
	logic [3:0] ph = '0;
	logic f_req;
	logic [17:0] f_addr;
	logic f_ack = 1'b0;
	logic [7:0] f_data = '0;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int dly = 0;
	logic [17:0] exp_fa = '0;
	logic [15:0] exp_q[$];
	logic [15:0] rw;
	logic [1:0] rr;
	logic [8:0] cd;
	logic sv;
	logic [7:0] dat;
	logic [7:0] msk;
	logic [7:0] eb;
	logic [3:0] rt;
	logic pb;
	int ln;

	always #2.5 clk_in = ~clk_in;

	mlsr_top #(.CLK_HZ(CLK_HZ), .SILO_DEPTH(64)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.rx_line_in(rx_line), .tx_line_out(tx_line), .ext_clk_a_in(ph[1]), .ext_clk_b_in(~ph[1]),
		.bus_master_fetch_req_out(f_req), .bus_master_fetch_addr_out(f_addr),
		.bus_master_fetch_ack_in(f_ack), .bus_master_fetch_data_in(f_data));

	mlsr_term_model #(.BIT_CYC(64)) TERM (.clk_in(clk_in), .rx_line_out(rx_line), .tx_line_in(tx_line));

	// External rate inputs rise every 4 cycles, the same pace as code 1101
	always @(posedge clk_in) ph <= ph + 4'h1;

	// Memory side of the fetch master: random latency, byte derived from the address
	always @(posedge clk_in) begin
		f_ack <= 1'b0;
		if (f_req === 1'b1 && !f_ack) begin
			if (dly == 0) begin
				f_ack <= 1'b1;
				f_data <= f_addr[7:0] ^ 8'h3c;
				`CHK(f_addr, exp_fa)
				exp_fa = exp_fa + 18'h1;
				dly <= $urandom % 4;
			end else begin
				dly <= dly - 1;
			end
		end
	end

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, mlsr_pkg::RESP_OKAY)
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata[15:0];
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		axi_rd(a, rw, rr);
		`CHK(rw, e)
	endtask

	// Model of the silo: oldest expected word first, zero once drained
	task automatic rx_pop();
		chk_rd(mlsr_pkg::ADDR_RXCHAR, (exp_q.size() != 0) ? exp_q.pop_front() : 16'h0000);
	endtask

	initial begin
		void'($urandom(32'h5904));
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		rx_pop();
		chk_rd(mlsr_pkg::ADDR_LCFG, 16'h0000);
		axi_rd(8'h18, rw, rr);
		`CHK(rr, mlsr_pkg::RESP_SLVERR)
		for (int i = 0; i < 4; i++) begin
			ln = i + 2;
			rt = (i == 1) ? 4'he : ((i == 2) ? 4'hf : 4'hd);
			msk = 8'hff >> (3 - i);
			axi_wr(mlsr_pkg::ADDR_CTRL, 16'(ln));
			axi_wr(mlsr_pkg::ADDR_LCFG, {2'b00, 4'hd, rt, i[1], i[0], 1'b0, i[1], i[1:0]});
			dat = 8'($urandom) & msk;
			pb = (^dat) ^ i[1];
			TERM.send_char(ln, dat, 5 + i, i[0], pb, 1'b1);
			exp_q.push_back({4'h8, 4'(ln), dat});
			if (i[0]) begin
				TERM.send_char(ln, dat, 5 + i, 1'b1, ~pb, 1'b1);
				exp_q.push_back({4'h9, 4'(ln), dat});
			end
			TERM.send_char(ln, dat, 5 + i, i[0], pb, 1'b0);
			exp_q.push_back({4'ha, 4'(ln), dat});
			repeat (20) @(posedge clk_in);
			while (exp_q.size() != 0) rx_pop();
			rx_pop();
		end
		axi_wr(mlsr_pkg::ADDR_CTRL, 16'h0025);
		axi_wr(mlsr_pkg::ADDR_LCFG, 16'h3756);
		axi_wr(mlsr_pkg::ADDR_TXADDR, 16'h12fe);
		exp_fa = 18'h212fe;
		chk_rd(mlsr_pkg::ADDR_TXADDR, 16'h12fe);
		chk_rd(mlsr_pkg::ADDR_SILOST, 16'h0080);
		axi_wr(mlsr_pkg::ADDR_TXCNT, 16'hfffd);
		chk_rd(mlsr_pkg::ADDR_TXCNT, 16'hfffd);
		axi_wr(mlsr_pkg::ADDR_TXACT, 16'h0020);
		for (int k = 0; k < 3; k++) begin
			TERM.get_char(5, 7, 1'b1, cd, sv);
			eb = (8'hfe + 8'(k)) ^ 8'h3c;
			`CHK(cd[6:0], eb[6:0])
			`CHK(cd[7], ^eb[6:0])
			`CHK(sv, 1'b1)
			// Active is already gone with the last character not yet started: modem leads must wait one more
			if (k == 1) chk_rd(mlsr_pkg::ADDR_TXACT, 16'h0000);
		end
		chk_rd(mlsr_pkg::ADDR_TXACT, 16'h0000);
		chk_rd(mlsr_pkg::ADDR_TXCNT, 16'h0000);
		chk_rd(mlsr_pkg::ADDR_TXADDR, 16'h1301);
		chk_rd(mlsr_pkg::ADDR_CTRL, 16'h8025);
		// Aborted buffer: count zero before activation must finish with no fetch at all
		axi_wr(mlsr_pkg::ADDR_CTRL, 16'h0006);
		chk_rd(mlsr_pkg::ADDR_CTRL, 16'h0006);
		axi_wr(mlsr_pkg::ADDR_TXCNT, 16'h0000);
		axi_wr(mlsr_pkg::ADDR_TXACT, 16'h0040);
		repeat (40) @(posedge clk_in);
		chk_rd(mlsr_pkg::ADDR_TXACT, 16'h0000);
		chk_rd(mlsr_pkg::ADDR_CTRL, 16'h8006);
		axi_wr(mlsr_pkg::ADDR_CTRL, 16'h0007);
		axi_wr(mlsr_pkg::ADDR_LCFG, 16'hf743);
		dat = 8'($urandom);
		// Second frame starts while the echo shifts out, so half duplex must drop it;
		// all-mark data keeps the line idle once the echo ends
		fork
			begin
				TERM.send_char(7, dat, 8, 1'b0, 1'b0, 1'b1);
				TERM.send_char(7, 8'hff, 8, 1'b0, 1'b0, 1'b1);
			end
			TERM.get_char(7, 8, 1'b0, cd, sv);
		join
		`CHK(cd[7:0], dat)
		exp_q.push_back({8'h87, dat});
		repeat (20) @(posedge clk_in);
		rx_pop();
		rx_pop();
		give_verdict();
	end
endmodule
